/* verilog/scd_pkg.sv */
package scd_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [31:0] SCD_SRC_SEL_ADDR = 32'h4004c300;
	localparam logic [31:0] SCD_DIV_CTRL_ADDR = 32'h4004c304;

	// ---------------------------------------------------------------
	// clock_divide_control fields
	// ---------------------------------------------------------------
	localparam int SCD_AUX_LSB = 16;
	localparam int SCD_AUX_MSB = 23;
	localparam int SCD_PER_LSB = 8;
	localparam int SCD_PER_MSB = 13;
	localparam int SCD_CORE_LSB = 0;
	localparam int SCD_CORE_MSB = 5;
	localparam logic [31:0] SCD_DIV_CTRL_MASK = 32'h00ff3f3f;
	localparam logic [31:0] SCD_DIV_CTRL_RESET = 32'h00100404;
	localparam logic [7:0] SCD_AUX_RESET = 8'h10;
	localparam logic [5:0] SCD_PER_RESET = 6'h04;
	localparam logic [5:0] SCD_CORE_RESET = 6'h04;

	// ---------------------------------------------------------------
	// root clock source select
	// ---------------------------------------------------------------
	localparam logic [31:0] SCD_SRC_SEL_MASK = 32'h00000003;
	localparam logic [1:0] SCD_SRC_RESET = 2'h0;

	// ---------------------------------------------------------------
	// ratio limits
	// ---------------------------------------------------------------
	localparam logic [7:0] SCD_RATIO_MAX = 8'h20;
	localparam logic [7:0] SCD_RATIO_MIN = 8'h01;

	typedef enum logic [1:0] {
		SCD_SRC_HF_OSC = 2'b00,
		SCD_SRC_RSV1 = 2'b01,
		SCD_SRC_RSV2 = 2'b10,
		SCD_SRC_EXT = 2'b11
	} scd_src_e;

	typedef struct packed {
		logic read;
		logic write;
		logic [31:0] address;
		logic [31:0] writedata;
	} scd_avm_req_s;

	typedef struct packed {
		logic [7:0] aux;
		logic [5:0] per;
		logic [5:0] core;
	} scd_div_cfg_s;

endpackage : scd_pkg

/* verilog/scd_divider.sv */
`timescale 1ns/10ps
module scd_divider #(
	parameter logic [5:0] RESET_RATIO = 6'h04
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] div_count,
	input wire logic hold,
	output logic tick,
	output logic clk_level
);
	import scd_pkg::*;

	logic [5:0] cnt_q;
	logic [5:0] ratio_q;
	logic [5:0] ratio_d;
	logic [5:0] half;
	logic boundary;
	logic [5:0] cnt_d;

	// ---------------------------------------------------------------
	// saturate the programmed count to 1..32
	// ---------------------------------------------------------------
	always_comb begin
		if (div_count > SCD_RATIO_MAX) begin
			ratio_d = SCD_RATIO_MAX[5:0]; // [R6]
		end else if (div_count == 8'h00) begin
			ratio_d = SCD_RATIO_MIN[5:0]; // [R7]
		end else begin
			ratio_d = div_count[5:0];
		end
	end

	assign boundary = (cnt_q == ratio_q - 6'h01);
	assign cnt_d = boundary ? 6'h00 : cnt_q + 6'h01;
	assign half = (ratio_q + 6'h01) >> 1;

	// ---------------------------------------------------------------
	// counter; ratio only changes at the end of an output period
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= 6'h00;
			ratio_q <= RESET_RATIO;
		end else if (!hold) begin
			cnt_q <= cnt_d;
			if (boundary) begin
				ratio_q <= ratio_d; // [R17]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick <= 1'b0;
			clk_level <= 1'b0;
		end else begin
			tick <= boundary && !hold;
			clk_level <= !hold && (cnt_d < half);
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_ratio_range: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
		(ratio_q >= 6'h01) && (ratio_q <= 6'h20))
		else $error("divider ratio outside 1..32");

	chk_ratio_switch: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
		!$stable(ratio_q) |-> $past(cnt_q) == $past(ratio_q) - 6'h01)
		else $error("divider ratio changed inside a period");

	chk_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
		$rose(tick) && ratio_q == 6'h02 && !hold |=> !tick ##1 tick)
		else $error("divide-by-two tick spacing wrong");

endmodule : scd_divider

/* verilog/scd_top.sv */
// What this block does
// R1: unused bits of the divider control register read as zero and the register is always open.
// R2: writes to unused bits are dropped and never disturb any divider setting.
// R3: the aux clock is the root clock divided by bits 23:16.
// R4: the peripheral clock is the root clock divided by bits 13:8.
// R5: the core/bus clock is the root clock divided by bits 5:0.
// R6: any count above 32 divides by exactly 32.
// R7: a count of zero divides by one, the same as a count of one.
// R8: a new aux count takes effect within about one aux clock cycle.
// R9: a new peripheral count takes effect within two to four peripheral cycles.
// R10: a new core/bus count takes effect within two to four peripheral cycles.
// R11: after reset the aux count is 0x10.
// R12: after reset the peripheral count is 0x4.
// R13: after reset the core/bus count is 0x4.
// R14: software should use only 1, 2 or 4 for peripheral and core/bus and keep them equal.
// R15: a two-bit root source select picks 00 internal oscillator or 11 external clock.
// R16: software clears the aux gate-off bit before programming the aux count.
// R17: each divider switches ratio only at an output clock boundary, never glitching.
`timescale 1ns/10ps
module scd_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire scd_pkg::scd_avm_req_s avm_req,
	output logic [31:0] avm_readdata,
	output logic avm_waitrequest,
	input wire logic aux_clock_gate_off,
	output scd_pkg::scd_src_e root_clock_source_select,
	output logic aux_clk_tick,
	output logic aux_clk,
	output logic periph_clk_tick,
	output logic periph_clk,
	output logic core_clk_tick,
	output logic core_clk
);
	import scd_pkg::*;

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	scd_div_cfg_s cfg_q;
	scd_src_e src_q;
	logic [7:0] aux_live_q;
	logic [5:0] core_stage_q;
	logic [31:0] rdata_q;
	logic wait_q;

	logic req;
	logic accept;
	logic hit_div;
	logic hit_src;
	logic [31:0] div_rd;
	logic [31:0] src_rd;
	logic [1:0] wr_src;

	assign req = avm_req.read || avm_req.write;
	// the access completes on the edge where waitrequest is seen low
	assign accept = req && !wait_q;
	assign hit_div = (avm_req.address == SCD_DIV_CTRL_ADDR);
	assign hit_src = (avm_req.address == SCD_SRC_SEL_ADDR);
	assign wr_src = avm_req.writedata[1:0];

	// unused positions are simply never wired, so they read back zero
	always_comb begin
		div_rd = 32'h00000000; // [R1]
		div_rd[SCD_AUX_MSB:SCD_AUX_LSB] = cfg_q.aux;
		div_rd[SCD_PER_MSB:SCD_PER_LSB] = cfg_q.per;
		div_rd[SCD_CORE_MSB:SCD_CORE_LSB] = cfg_q.core;
		src_rd = 32'h00000000;
		src_rd[1:0] = src_q;
	end

	// ---------------------------------------------------------------
	// avalon slave handshake: one wait state on every access
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wait_q <= 1'b1;
		end else if (req && wait_q) begin
			wait_q <= 1'b0; // [R1]
		end else begin
			wait_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= 32'h00000000;
		end else if (avm_req.read && wait_q) begin
			if (hit_div) begin
				rdata_q <= div_rd;
			end else if (hit_src) begin
				rdata_q <= src_rd;
			end else begin
				rdata_q <= 32'h00000000;
			end
		end
	end

	assign avm_waitrequest = wait_q;
	assign avm_readdata = rdata_q;

	// ---------------------------------------------------------------
	// divider control register
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_q.aux <= SCD_AUX_RESET; // [R11]
			cfg_q.per <= SCD_PER_RESET; // [R12]
			cfg_q.core <= SCD_CORE_RESET; // [R13]
		end else if (accept && avm_req.write && hit_div) begin
			// only field bits are taken; bits 31:24, 15:14, 7:6 are dropped
			cfg_q.aux <= avm_req.writedata[SCD_AUX_MSB:SCD_AUX_LSB]; // [R2]
			cfg_q.per <= avm_req.writedata[SCD_PER_MSB:SCD_PER_LSB]; // [R2]
			cfg_q.core <= avm_req.writedata[SCD_CORE_MSB:SCD_CORE_LSB]; // [R2]
		end
	end

	// ---------------------------------------------------------------
	// root source select
	// ---------------------------------------------------------------
	// reserved codes would leave the root clock undefined, so they are refused
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			src_q <= SCD_SRC_HF_OSC;
		end else if (accept && avm_req.write && hit_src) begin
			if (wr_src == SCD_SRC_HF_OSC || wr_src == SCD_SRC_EXT) begin
				src_q <= scd_src_e'(wr_src); // [R15]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			root_clock_source_select <= SCD_SRC_HF_OSC;
		end else begin
			root_clock_source_select <= src_q; // [R15]
		end
	end

	// ---------------------------------------------------------------
	// aux count is frozen while its gate is off
	// ---------------------------------------------------------------
	// with the gate off a newly written count is not handed to the divider
	// it stays lost after the gate opens: software must write the count again
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aux_live_q <= SCD_AUX_RESET;
		end else if (accept && avm_req.write && hit_div && !aux_clock_gate_off) begin
			aux_live_q <= avm_req.writedata[SCD_AUX_MSB:SCD_AUX_LSB]; // [R16] [R8]
		end
	end

	// ---------------------------------------------------------------
	// core count is retimed to the peripheral clock
	// ---------------------------------------------------------------
	// core switches at the first core boundary after the peripheral tick, two cycles or more after the peripheral divider switches
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			core_stage_q <= SCD_CORE_RESET;
		end else if (periph_clk_tick) begin
			core_stage_q <= cfg_q.core; // [R10]
		end
	end

	// ---------------------------------------------------------------
	// dividers
	// ---------------------------------------------------------------
	scd_divider #(
		.RESET_RATIO(SCD_AUX_RESET[5:0])
	) u_aux_div (
		.clk(clk),
		.rst_n(rst_n),
		.div_count(aux_live_q), // [R3] [R8]
		.hold(aux_clock_gate_off),
		.tick(aux_clk_tick),
		.clk_level(aux_clk)
	);

	scd_divider #(
		.RESET_RATIO(SCD_PER_RESET)
	) u_per_div (
		.clk(clk),
		.rst_n(rst_n),
		.div_count({2'h0, cfg_q.per}), // [R4] [R9]
		.hold(1'b0),
		.tick(periph_clk_tick),
		.clk_level(periph_clk)
	);

	scd_divider #(
		.RESET_RATIO(SCD_CORE_RESET)
	) u_core_div (
		.clk(clk),
		.rst_n(rst_n),
		.div_count({2'h0, core_stage_q}), // [R5]
		.hold(1'b0),
		.tick(core_clk_tick),
		.clk_level(core_clk)
	);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	logic [7:0] per_gap_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			per_gap_q <= 8'h00;
		end else if (periph_clk_tick) begin
			per_gap_q <= 8'h00;
		end else if (per_gap_q != 8'hff) begin
			per_gap_q <= per_gap_q + 8'h01;
		end
	end

	chk_unused_zero: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
		$fell(avm_waitrequest) && $past(avm_req.read) && $past(hit_div)
		|-> (avm_readdata & ~SCD_DIV_CTRL_MASK) == 32'h00000000)
		else $error("unused divider bits read nonzero");

	chk_unused_write: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		accept && avm_req.write && hit_div |=>
		cfg_q == {$past(avm_req.writedata[23:16]), $past(avm_req.writedata[13:8]),
		$past(avm_req.writedata[5:0])})
		else $error("divider fields not taken from write data");

	chk_readback: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
		req && wait_q && avm_req.read && hit_div |=> !avm_waitrequest
		&& avm_readdata == div_rd)
		else $error("divider register readback wrong");

	chk_one_wait: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
		req && avm_waitrequest |=> !avm_waitrequest ##1 avm_waitrequest)
		else $error("access not answered after one wait state");

	chk_reset_vals: assert property (@(posedge clk) // [R11]
		!rst_n |=> div_rd == SCD_DIV_CTRL_RESET)
		else $error("divider register reset value wrong");

	chk_per_period: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
		periph_clk_tick && per_gap_q != 8'hff
		|-> per_gap_q + 8'h01 <= SCD_RATIO_MAX)
		else $error("peripheral period longer than 32");

	chk_src_legal: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
		root_clock_source_select == SCD_SRC_HF_OSC || root_clock_source_select == SCD_SRC_EXT)
		else $error("reserved root source selected");

	chk_aux_frozen: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
		aux_clock_gate_off |=> $stable(aux_live_q) && !aux_clk_tick)
		else $error("aux divider moved while gated off");

	chk_core_stage: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
		!$stable(core_stage_q) |-> $past(periph_clk_tick))
		else $error("core count changed off a peripheral tick");

	chk_per_reset: assert property (@(posedge clk) // [R12]
		!rst_n |=> cfg_q.per == 6'h04 && cfg_q.core == 6'h04)
		else $error("peripheral or core reset count wrong");

endmodule : scd_top

/* verification/scd_top_tb.sv */
`timescale 1ns/10ps
module scd_top_tb;
	import scd_pkg::*;
	// ---------------------------------------------------------------
	// clock, reset, stimulus signals
	// ---------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	scd_avm_req_s avm_req = '0;
	logic aux_clock_gate_off = 1'b0;
	logic [31:0] avm_readdata;
	logic avm_waitrequest;
	scd_src_e root_clock_source_select;
	logic aux_clk_tick, aux_clk, periph_clk_tick, periph_clk, core_clk_tick, core_clk;
	int err_total = 0;
	int checked = 0;
	int cyc = 0;
	logic [31:0] exp_q[$];
	logic [31:0] rnd = 32'hfa9d;
	logic [31:0] tbl[6] = '{32'h0, 32'h00210221, 32'h00ff3f3f, 32'h00200101, 32'h00070504,
		32'h00100404};
	int p, h, s, i;

	scd_top i_dut (.clk(clk), .rst_n(rst_n), .avm_req(avm_req), .avm_readdata(avm_readdata),
		.avm_waitrequest(avm_waitrequest), .aux_clock_gate_off(aux_clock_gate_off),
		.root_clock_source_select(root_clock_source_select), .aux_clk_tick(aux_clk_tick),
		.aux_clk(aux_clk), .periph_clk_tick(periph_clk_tick), .periph_clk(periph_clk),
		.core_clk_tick(core_clk_tick), .core_clk(core_clk));

	initial begin
		forever #5 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic end_of_test;
		if (err_total == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	function automatic int clp(input int v);
		return (v == 0) ? 1 : ((v > 32) ? 32 : v);
	endfunction : clp

	// 0 aux, 1 peripheral, 2 core/bus
	function automatic logic tk(input int sel);
		return (sel == 0) ? aux_clk_tick : ((sel == 1) ? periph_clk_tick : core_clk_tick);
	endfunction : tk

	function automatic logic lv(input int sel);
		return (sel == 0) ? aux_clk : ((sel == 1) ? periph_clk : core_clk);
	endfunction : lv

	// one avalon access; request held until waitrequest is seen low at an edge
	task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avm_req <= '{read: ~wr, write: wr, address: a, writedata: d};
		do begin
			@(posedge clk);
			n++;
		end while (avm_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			err_total++;
		avm_req.read <= 1'b0;
		avm_req.write <= 1'b0;
	endtask : acc

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		acc(1'b0, a, 32'h0);
	endtask : rd

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask : wr

	// cycles from one tick to the next, and cycles with the level high in between
	task automatic meas(input int sel, output int per, output int hi);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (tk(sel) !== 1'b1 && n < 200);
		per = 0;
		hi = 0;
		do begin
			@(posedge clk);
			per++;
			if (lv(sel) === 1'b1)
				hi++;
		end while (tk(sel) !== 1'b1 && per < 200);
	endtask : meas

	// ratio change: every period is old or new, new one arrives within lim periods
	task automatic chg(input int sel, input int o, input int n, input int lim, input logic [31:0] v);
		int k, first, pp, hh;
		first = -1;
		wr(SCD_DIV_CTRL_ADDR, v);
		for (k = 0; k < 6; k++) begin
			meas(sel, pp, hh);
			if (pp != o && pp != n)
				chk("period during switch", n, pp);
			if (pp == n && first < 0)
				first = k;
			if (first >= 0)
				chk("period after switch", n, pp);
		end
		chk("switch delay", 1, (first >= 0 && first <= lim) ? 1 : 0);
	endtask : chg

	// ---------------------------------------------------------------
	// read data monitor: oldest note against each read answer
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		if (rst_n && avm_req.read && avm_waitrequest === 1'b0)
			chk("readdata", (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdead0000, avm_readdata);
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_of_test();
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(SCD_DIV_CTRL_ADDR, 32'h00100404);
		rd(SCD_SRC_SEL_ADDR, 32'h0);
		rd(32'h40000000, 32'h0);
		foreach (tbl[t]) begin
			wr(SCD_DIV_CTRL_ADDR, tbl[t] | 32'hff00c0c0);
			rd(SCD_DIV_CTRL_ADDR, tbl[t]);
			repeat (300) @(posedge clk);
			for (s = 0; s < 3; s++) begin
				i = (s == 0) ? tbl[t][23:16] : ((s == 1) ? tbl[t][13:8] : tbl[t][5:0]);
				meas(s, p, h);
				chk("divided period", clp(i), p);
				chk("high cycles", (clp(i) + 1) / 2, h);
			end
		end
		// peripheral and core/bus counts move together, as software is asked to keep them
		chg(1, 4, 2, 3, 32'h00100202);
		chg(2, 2, 4, 3, 32'h00100404);
		chg(0, 16, 8, 1, 32'h00080404);
		for (i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			wr(SCD_DIV_CTRL_ADDR, rnd);
			wr(32'h4004c3f0, ~rnd);
			rd(SCD_DIV_CTRL_ADDR, rnd & SCD_DIV_CTRL_MASK);
		end
		wr(SCD_SRC_SEL_ADDR, 32'h3);
		rd(SCD_SRC_SEL_ADDR, 32'h3);
		chk("source port", SCD_SRC_EXT, root_clock_source_select);
		wr(SCD_SRC_SEL_ADDR, 32'h1);
		rd(SCD_SRC_SEL_ADDR, 32'h3);
		wr(SCD_SRC_SEL_ADDR, 32'h0);
		rd(SCD_SRC_SEL_ADDR, 32'h0);
		chk("source port", SCD_SRC_HF_OSC, root_clock_source_select);
		// gated aux clock: no ticks, level low, and a count written meanwhile is not taken
		wr(SCD_DIV_CTRL_ADDR, 32'h00080202);
		repeat (100) @(posedge clk);
		aux_clock_gate_off <= 1'b1;
		repeat (3) @(posedge clk);
		wr(SCD_DIV_CTRL_ADDR, 32'h00030202);
		h = 0;
		for (i = 0; i < 80; i++) begin
			@(posedge clk);
			h += (aux_clk_tick !== 1'b0 || aux_clk !== 1'b0) ? 1 : 0;
		end
		chk("gated aux activity", 0, h);
		aux_clock_gate_off <= 1'b0;
		meas(0, p, h);
		meas(0, p, h);
		chk("aux period after gate", 8, p);
		repeat (5) @(posedge clk);
		chk("notes left", 0, exp_q.size());
		end_of_test();
	end
endmodule : scd_top_tb
